// File: logic/nbc_pkg.sv
// Purpose: constants for the host-side strobe sequencer of an 8-bit flash port
// Assumes: clk at 100 MHz
// Notes: pin timings are plain defaults, tune them for the attached part
`default_nettype none
package nbc_pkg;
    localparam int CLK_MHZ = 100;
    // pin timing in ns
    localparam int SETUP_NS = 20;
    localparam int WE_LOW_NS = 25;
    localparam int WE_HIGH_NS = 15;
    localparam int READ_ACCESS_DELAY_NS = 25;
    localparam int WB_NS = 100;
    // least times, rounded up to whole cycles
    localparam logic [4:0] SETUP_CYC = 5'((SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] WE_LOW_CYC = 5'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] WE_HIGH_CYC = 5'((WE_HIGH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] READ_ACCESS_CYC = 5'((READ_ACCESS_DELAY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] WB_CYC = 5'((WB_NS * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] SYNC_CYC = 5'h02;
    // array geometry
    localparam logic [12:0] PAGE_BYTES = 13'h10e8;
    localparam logic [12:0] MAIN_BYTES = 13'h1000;
    localparam logic [12:0] SPARE_BYTES = 13'h00e8;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int PAGE_IDX_W = 6;
    localparam int BLOCK_W = 12;
    localparam logic [2:0] ADDR_FULL_CYCLES = 3'h5;
    localparam logic [2:0] ADDR_COL_CYCLES = 3'h2;
    // command codes
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_READ_START = 8'h30;
    localparam logic [7:0] CMD_OUT_COL = 8'h05;
    localparam logic [7:0] CMD_OUT_COL_GO = 8'he0;
    localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
    localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
    localparam logic [7:0] CMD_DATA_LOAD = 8'h80;
    localparam logic [7:0] CMD_PROG = 8'h10;
    localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
    localparam logic [7:0] CMD_PROG_MULTI = 8'h11;
    localparam logic [7:0] CMD_DATA_LOAD2 = 8'h81;
    localparam logic [7:0] CMD_IN_COL = 8'h85;
    localparam logic [7:0] CMD_COPY_READ = 8'h35;
    localparam logic [7:0] CMD_COPY_READ_OUT = 8'h3a;
    localparam logic [7:0] CMD_COPY_PROG = 8'h8c;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
    localparam logic [7:0] CMD_ID_READ = 8'h90;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS2 = 8'hf1;
    localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam int STATUS_FAIL_BIT = 0;
    typedef enum logic [2:0] {
        NBC_K_CMD = 3'h0,
        NBC_K_ADDR = 3'h1,
        NBC_K_ADDR_COL = 3'h2,
        NBC_K_WDATA = 3'h3,
        NBC_K_RDATA = 3'h4
    } nbc_kind_t;
    typedef enum logic [1:0] {
        NBC_S_IDLE = 2'b00,
        NBC_S_SETUP = 2'b01,
        NBC_S_LOW = 2'b11,
        NBC_S_HIGH = 2'b10
    } nbc_state_t;
endpackage : nbc_pkg
`default_nettype wire

// File: logic/nbc_host.sv
// Purpose: host sequencer driving command, address and data cycles on a flash port
// Assumes: one user operation at a time; ready_busy_n pulled up off chip
// Notes: pins are registered; inputs from pins pass two flip-flops
`timescale 1ns/1ps
`default_nettype none
module nbc_host
    import nbc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic user_valid,
    input wire logic [2:0] user_kind,
    input wire logic [7:0] user_byte,
    input wire logic [12:0] user_col,
    input wire logic [BLOCK_W-1:0] user_block,
    input wire logic [PAGE_IDX_W-1:0] user_page,
    input wire logic user_write_allow,
    input wire logic cfg_power_on_init,
    output logic user_ready,
    output logic user_refused,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic prog_fail,
    output logic [12:0] col_count,
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic output_strobe_n,
    output logic wp_n,
    output logic power_on_init_select,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic [7:0] io_in,
    input wire logic ready_busy_n
);
    function automatic logic busy_ok(input logic [7:0] c);
        busy_ok = (c == CMD_STATUS) || (c == CMD_STATUS2) ||
                  (c == CMD_STATUS_MULTI) || (c == CMD_RESET);
    endfunction : busy_ok

    function automatic logic is_status(input logic [7:0] c);
        is_status = (c == CMD_STATUS) || (c == CMD_STATUS2) || (c == CMD_STATUS_MULTI);
    endfunction : is_status

    function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [12:0] c,
                                             input logic [17:0] r);
        case (i)
            3'h0: addr_byte = c[7:0];
            3'h1: addr_byte = {3'h0, c[12:8]};
            3'h2: addr_byte = r[7:0];
            3'h3: addr_byte = r[15:8];
            default: addr_byte = {6'h00, r[17:16]};
        endcase
    endfunction : addr_byte

    logic rst_meta_q, rst_sync_q;
    logic [7:0] io_m_q, io_s_q;
    logic rb_m_q, rb_s_q;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
            io_m_q <= 8'h00;
            io_s_q <= 8'h00;
            rb_m_q <= 1'b0;
            rb_s_q <= 1'b0;
        end
        else if (clk_en)
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
            io_m_q <= io_in;
            io_s_q <= io_m_q;
            rb_m_q <= ready_busy_n;
            rb_s_q <= rb_m_q;
        end
    end
    logic busy;
    assign busy = !rb_s_q;

    nbc_state_t st_q, st_d;
    nbc_kind_t kind_q, kind_d;
    logic [4:0] cnt_q, cnt_d, wb_q, wb_d;
    logic [2:0] idx_q, idx_d;
    logic [12:0] col_q, col_d, colc_q, colc_d;
    logic [17:0] row_q, row_d;
    logic ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d;
    logic [7:0] io_out_q, io_out_d, rd_data_q, rd_data_d;
    logic io_oe_q, io_oe_d, rd_valid_q, rd_valid_d, ref_q, ref_d, rdy_q, rdy_d;
    logic stat_q, stat_d, fail_q, fail_d, wp_n_q, psl_q, psl_d, psl_taken_q;
    logic take, is_addr, bad;
    logic [2:0] last_idx;

    always_comb
    begin
        st_d = st_q;
        kind_d = kind_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        col_d = col_q;
        row_d = row_q;
        colc_d = colc_q;
        ce_n_d = ce_n_q;
        cle_d = cle_q;
        ale_d = ale_q;
        we_n_d = we_n_q;
        re_n_d = re_n_q;
        io_out_d = io_out_q;
        io_oe_d = io_oe_q;
        rd_data_d = rd_data_q;
        rd_valid_d = 1'b0;
        ref_d = 1'b0;
        stat_d = stat_q;
        fail_d = fail_q;
        wb_d = (wb_q != 5'h00) ? wb_q - 5'h01 : wb_q;
        take = user_valid && rdy_q;
        is_addr = (kind_q == NBC_K_ADDR) || (kind_q == NBC_K_ADDR_COL);
        last_idx = (kind_q == NBC_K_ADDR) ? ADDR_FULL_CYCLES : ADDR_COL_CYCLES;
        // busy device hears only status and reset; writes need the guard high
        bad = (busy && !(user_kind == NBC_K_CMD && busy_ok(user_byte))) ||
              (user_kind == NBC_K_WDATA && !wp_n_q) ||
              (user_kind > NBC_K_RDATA) ||
              ((user_kind == NBC_K_ADDR || user_kind == NBC_K_ADDR_COL) &&
               user_col >= PAGE_BYTES);
        case (st_q)
            NBC_S_IDLE:
            begin
                if (take && bad)
                begin
                    ref_d = 1'b1;
                end
                else if (take)
                begin
                    kind_d = nbc_kind_t'(user_kind);
                    col_d = user_col;
                    row_d = {user_block, user_page};
                    idx_d = 3'h0;
                    st_d = NBC_S_SETUP;
                    cnt_d = SETUP_CYC;
                    ce_n_d = 1'b0;
                    cle_d = (user_kind == NBC_K_CMD);
                    ale_d = (user_kind == NBC_K_ADDR) || (user_kind == NBC_K_ADDR_COL);
                    io_oe_d = (user_kind != NBC_K_RDATA);
                    io_out_d = (user_kind == NBC_K_ADDR || user_kind == NBC_K_ADDR_COL) ?
                               addr_byte(3'h0, user_col, {user_block, user_page}) :
                               user_byte;
                    if (user_kind == NBC_K_CMD)
                    begin
                        stat_d = is_status(user_byte);
                    end
                    if (user_kind == NBC_K_ADDR || user_kind == NBC_K_ADDR_COL)
                    begin
                        colc_d = user_col;
                    end
                end
            end
            NBC_S_SETUP:
            begin
                if (cnt_q == 5'h01)
                begin
                    st_d = NBC_S_LOW;
                    if (kind_q == NBC_K_RDATA)
                    begin
                        cnt_d = READ_ACCESS_CYC + SYNC_CYC;
                        re_n_d = 1'b0;
                    end
                    else
                    begin
                        cnt_d = WE_LOW_CYC;
                        we_n_d = 1'b0;
                    end
                end
                else
                begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            NBC_S_LOW:
            begin
                if (cnt_q == 5'h01)
                begin
                    st_d = NBC_S_HIGH;
                    cnt_d = WE_HIGH_CYC;
                    we_n_d = 1'b1;
                    re_n_d = 1'b1;
                    idx_d = idx_q + 3'h1;
                    if (kind_q == NBC_K_RDATA)
                    begin
                        rd_data_d = io_s_q;
                        rd_valid_d = 1'b1;
                        colc_d = colc_q + 13'h0001;
                        if (stat_q)
                        begin
                            fail_d = io_s_q[STATUS_FAIL_BIT];
                        end
                    end
                    if (kind_q == NBC_K_WDATA)
                    begin
                        colc_d = colc_q + 13'h0001;
                    end
                end
                else
                begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            NBC_S_HIGH:
            begin
                if (cnt_q != 5'h01)
                begin
                    cnt_d = cnt_q - 5'h01;
                end
                else if (is_addr && idx_q != last_idx)
                begin
                    st_d = NBC_S_SETUP;
                    cnt_d = SETUP_CYC;
                    io_out_d = addr_byte(idx_q, col_q, row_q);
                end
                else
                begin
                    st_d = NBC_S_IDLE;
                    ce_n_d = 1'b1;
                    cle_d = 1'b0;
                    ale_d = 1'b0;
                    io_oe_d = 1'b0;
                    if (kind_q == NBC_K_CMD)
                    begin
                        wb_d = WB_CYC;
                    end
                end
            end
            default:
            begin
                st_d = NBC_S_IDLE;
            end
        endcase
        rdy_d = (st_d == NBC_S_IDLE) && (wb_d == 5'h00);
        psl_d = psl_taken_q ? psl_q : cfg_power_on_init;
    end

    always_ff @(posedge clk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            st_q <= NBC_S_IDLE;
            kind_q <= NBC_K_CMD;
            cnt_q <= 5'h00;
            wb_q <= 5'h00;
            idx_q <= 3'h0;
            col_q <= 13'h0000;
            row_q <= 18'h00000;
            colc_q <= 13'h0000;
            ce_n_q <= 1'b1;
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            we_n_q <= 1'b1;
            re_n_q <= 1'b1;
            io_out_q <= 8'h00;
            io_oe_q <= 1'b0;
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
            ref_q <= 1'b0;
            rdy_q <= 1'b0;
            stat_q <= 1'b0;
            fail_q <= 1'b0;
            wp_n_q <= 1'b0;
            psl_q <= 1'b0;
            psl_taken_q <= 1'b0;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            wb_q <= wb_d;
            idx_q <= idx_d;
            col_q <= col_d;
            row_q <= row_d;
            colc_q <= colc_d;
            ce_n_q <= ce_n_d;
            cle_q <= cle_d;
            ale_q <= ale_d;
            we_n_q <= we_n_d;
            re_n_q <= re_n_d;
            io_out_q <= io_out_d;
            io_oe_q <= io_oe_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            ref_q <= ref_d;
            rdy_q <= rdy_d;
            stat_q <= stat_d;
            fail_q <= fail_d;
            wp_n_q <= user_write_allow;
            psl_q <= psl_d;
            psl_taken_q <= 1'b1;
        end
    end

    assign user_ready = rdy_q;
    assign user_refused = ref_q;
    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign prog_fail = fail_q;
    assign col_count = colc_q;
    assign ce_n = ce_n_q;
    assign cle = cle_q;
    assign ale = ale_q;
    assign we_n = we_n_q;
    assign output_strobe_n = re_n_q;
    assign wp_n = wp_n_q;
    assign power_on_init_select = psl_q;
    assign io_out = io_out_q;
    assign io_oe = io_oe_q;

    property p_cmd_latch;
        @(posedge clk) disable iff (!rst_sync_q)
        $rose(we_n_q) && cle_q |-> !ale_q && re_n_q && !ce_n_q && io_oe_q;
    endproperty
    a_cmd_latch: assert property (p_cmd_latch) else $error("bad command cycle");
    property p_addr_latch;
        @(posedge clk) disable iff (!rst_sync_q)
        $rose(we_n_q) && ale_q |-> !cle_q && io_oe_q && !ce_n_q;
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("bad address cycle");
    property p_col_high;
        @(posedge clk) disable iff (!rst_sync_q)
        st_q == NBC_S_LOW && ale_q && idx_q == 3'h1 |-> io_out_q[7:5] == 3'h0;
    endproperty
    a_col_high: assert property (p_col_high) else $error("column high bits set");
    property p_read_release;
        @(posedge clk) disable iff (!rst_sync_q)
        !re_n_q |-> !io_oe_q && we_n_q;
    endproperty
    a_read_release: assert property (p_read_release) else $error("port driven in read");
    property p_busy_refuse;
        @(posedge clk) disable iff (!rst_sync_q)
        user_valid && rdy_q && busy && user_kind != NBC_K_CMD
        |=> ref_q && st_q == NBC_S_IDLE && we_n_q && re_n_q;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse) else $error("busy op started");
    property p_col_step;
        @(posedge clk) disable iff (!rst_sync_q)
        $rose(re_n_q) |-> rd_valid_q && colc_q == $past(colc_q) + 13'h0001;
    endproperty
    a_col_step: assert property (p_col_step) else $error("column not advanced");
    property p_guard;
        @(posedge clk) disable iff (!rst_sync_q)
        user_valid && rdy_q && !wp_n_q && user_kind == NBC_K_WDATA |=> ref_q;
    endproperty
    a_guard: assert property (p_guard) else $error("write under guard");
    property p_standby;
        @(posedge clk) disable iff (!rst_sync_q)
        rdy_q |-> ce_n_q && we_n_q && re_n_q && !io_oe_q;
    endproperty
    a_standby: assert property (p_standby) else $error("select low while idle");
    property p_status_fail;
        @(posedge clk) disable iff (!rst_sync_q)
        rd_valid_q && stat_q |-> fail_q == rd_data_q[STATUS_FAIL_BIT];
    endproperty
    a_status_fail: assert property (p_status_fail) else $error("fail flag stale");
    property p_holdoff;
        @(posedge clk) disable iff (!rst_sync_q)
        $rose(we_n_q) && cle_q |=> !rdy_q [*8];
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("ready too soon");
    c_cmd: cover property (@(posedge clk) $rose(we_n_q) && cle_q);
    c_addr5: cover property (@(posedge clk) $fell(ale_q) && idx_q == ADDR_FULL_CYCLES);
    c_read: cover property (@(posedge clk) rd_valid_q);
    c_refuse: cover property (@(posedge clk) ref_q);
endmodule : nbc_host
`default_nettype wire

// File: dv/nbc_dev_model.sv
// Purpose: behavioural flash device on the far side of the host sequencer
// Assumes: strobes come from nbc_host; the bench pulls the busy line up
// Notes: busy and access times are plain defaults, shorter than a real part
`timescale 1ns/1ps
`default_nettype none
module nbc_dev_model
    import nbc_pkg::*;
#(
    parameter int BUSY_NS = 2000,
    parameter int ACCESS_NS = 20
)
(
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic output_strobe_n,
    input wire logic wp_n,
    input wire logic [7:0] io,
    output logic [7:0] dq,
    output logic dq_oe,
    output logic rb_low
);
    logic [7:0] cmd_q = CMD_READ_SETUP;
    logic [7:0] addr_q [5];
    logic [7:0] buf_q [0:PAGE_BYTES-1];
    logic [7:0] mem [int];
    logic [2:0] n_addr = 3'h0;
    logic [12:0] col = 13'h0000;
    logic busy = 1'b0;
    logic fail = 1'b0;
    logic multi = 1'b0;
    logic stat = 1'b0;
    logic standby;
    logic [17:0] row;
    int n_viol = 0;
    int n_prog = 0;
    initial dq = 8'h00;
    assign row = {addr_q[4][1:0], addr_q[3], addr_q[2]};
    assign standby = ce_n && !busy;
    assign rb_low = busy;
    assign dq_oe = !ce_n && we_n && !output_strobe_n;
    function automatic int key(input logic [12:0] c);
        return int'({row[17:6], row[5:0], c});
    endfunction : key
    task automatic hold_busy();
        #50;
        busy = 1'b1;
        #(BUSY_NS);
        busy = 1'b0;
    endtask : hold_busy
    always @(posedge we_n)
    begin
        if (!ce_n)
        begin
            if (busy && !(cle && io inside {CMD_STATUS, CMD_STATUS2, CMD_STATUS_MULTI, CMD_RESET}))
                n_viol++;
            else if (cle && !ale)
            begin
                cmd_q = io;
                n_addr = 3'h0;
                stat = io inside {CMD_STATUS, CMD_STATUS2, CMD_STATUS_MULTI};
                case (io)
                    CMD_READ_START, CMD_COPY_READ, CMD_COPY_READ_OUT, CMD_CACHE_NEXT:
                    begin
                        for (int i = 0; i < int'(PAGE_BYTES); i++)
                            buf_q[i] = mem.exists(key(13'(i))) ? mem[key(13'(i))] : 8'hff;
                        fork
                            hold_busy();
                        join_none
                    end
                    CMD_PROG, CMD_PROG_CACHE, CMD_PROG_MULTI, CMD_ERASE_GO:
                    begin
                        fail = (fail && multi) || !wp_n;
                        multi = (io == CMD_PROG_MULTI);
                        if (wp_n)
                        begin
                            for (int i = 0; i < int'(PAGE_BYTES); i++)
                                mem[key(13'(i))] = buf_q[i];
                            n_prog++;
                            fork
                                hold_busy();
                            join_none
                        end
                    end
                    CMD_DATA_LOAD:
                        foreach (buf_q[i]) buf_q[i] = 8'hff;
                    default:
                        ;
                endcase
            end
            else if (ale && !cle && n_addr < ADDR_FULL_CYCLES)
            begin
                addr_q[n_addr] = io;
                n_addr++;
                if (n_addr == ADDR_COL_CYCLES)
                    col = {addr_q[1][4:0], addr_q[0]};
            end
            else if (!ale && !cle && wp_n)
            begin
                buf_q[col] = io;
                col++;
            end
        end
    end
    always @(negedge output_strobe_n)
    begin
        if (!ce_n)
        begin
            if (busy)
                n_viol++;
            dq = ~dq;
            #(ACCESS_NS);
            dq = stat ? {wp_n, !busy, 5'h00, fail} : buf_q[col];
            col = stat ? col : col + 13'h1;
        end
    end
endmodule : nbc_dev_model
`default_nettype wire

// File: dv/nand_bus_command_interface_tb_top.sv
// Purpose: self-checking bench for the host strobe sequencer
// Assumes: device model on the far side, busy line pulled up here
// Notes: each scenario is a task of its own
`timescale 1ns/1ps
`default_nettype none
module nand_bus_command_interface_tb_top;
    import nbc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic user_valid = 1'b0;
    logic [2:0] user_kind = 3'h0;
    logic [7:0] user_byte = 8'h00;
    logic [12:0] user_col = 13'h0000;
    logic [11:0] user_block = 12'hca5;
    logic [5:0] user_page = 6'h07;
    logic user_write_allow = 1'b1;
    logic clk_en = 1'b1;
    logic cfg_psl = 1'b1;
    logic user_ready, user_refused, rd_valid, prog_fail, ce_n, cle, ale, we_n, output_strobe_n;
    logic wp_n, power_on_init_select, io_oe, dq_oe, rb_low, refd;
    logic rb_seen = 1'b0;
    logic [7:0] rd_data, io_out, dq;
    logic [7:0] rd_got = 8'h00;
    logic [7:0] io_last = 8'h00;
    logic [12:0] col_count;
    wire logic [7:0] io_bus;
    wire logic ready_busy_n;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    // undriven port shows a changing pattern, busy line has a pull-up
    assign io_bus = io_oe ? io_out : (dq_oe ? dq : ~io_last);
    assign ready_busy_n = rb_low ? 1'b0 : 1'b1;
    always #5 clk = ~clk;
    nbc_host dut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .user_valid(user_valid),
        .user_kind(user_kind), .user_byte(user_byte), .user_col(user_col),
        .user_block(user_block), .user_page(user_page), .user_write_allow(user_write_allow),
        .cfg_power_on_init(cfg_psl), .user_ready(user_ready), .user_refused(user_refused),
        .rd_data(rd_data), .rd_valid(rd_valid), .prog_fail(prog_fail), .col_count(col_count),
        .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .output_strobe_n(output_strobe_n),
        .wp_n(wp_n), .power_on_init_select(power_on_init_select), .io_out(io_out),
        .io_oe(io_oe), .io_in(io_bus), .ready_busy_n(ready_busy_n));
    nbc_dev_model dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .output_strobe_n(output_strobe_n), .wp_n(wp_n), .io(io_bus), .dq(dq),
        .dq_oe(dq_oe), .rb_low(rb_low));
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    always @(posedge clk)
    begin
        io_last <= io_bus;
        cyc <= cyc + 1;
        if (rd_valid === 1'b1)
            rd_got <= rd_data;
        if (ready_busy_n === 1'b0)
            rb_seen <= 1'b1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic idle();
        int n;
        n = 0;
        while (user_ready !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (user_ready !== 1'b1)
            n_mismatch++;
    endtask : idle
    task automatic op(input logic [2:0] k, input logic [7:0] b, input logic [12:0] c);
        idle();
        user_kind = k;
        user_byte = b;
        user_col = c;
        user_valid = 1'b1;
        @(posedge clk);
        #1;
        user_valid = 1'b0;
        refd = 1'b0;
        repeat (3)
        begin
            if (user_refused === 1'b1)
                refd = 1'b1;
            @(posedge clk);
            #1;
        end
        // let the whole sequence finish before anyone looks at the far side
        idle();
    endtask : op
    task automatic rd();
        op(3'h4, 8'h00, 13'h0000);
        repeat (8) @(posedge clk);
        #1;
    endtask : rd
    task automatic wait_rb();
        int n;
        n = 0;
        idle();
        while (ready_busy_n !== 1'b1 && n < 1000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (ready_busy_n !== 1'b1)
            n_mismatch++;
        repeat (4) @(posedge clk);
        #1;
    endtask : wait_rb
    task automatic t_prog_read();
        logic [17:0] r;
        r = {user_block, user_page};
        op(3'h0, CMD_DATA_LOAD, 13'h0000);
        chk("cmd byte", dev.cmd_q, 18'h80);
        op(3'h1, 8'h00, 13'h0003);
        chk("addr cycles", dev.n_addr, 18'h5);
        chk("addr col lo", dev.addr_q[0], 18'h03);
        chk("addr col hi", dev.addr_q[1], 18'h00);
        chk("addr row lo", dev.addr_q[2], 18'(r[7:0]));
        chk("addr row mid", dev.addr_q[3], 18'(r[15:8]));
        chk("addr row top", dev.addr_q[4], 18'(r[17:16]));
        op(3'h3, 8'ha5, 13'h0000);
        op(3'h3, 8'h3c, 13'h0000);
        op(3'h0, CMD_PROG, 13'h0000);
        wait_rb();
        chk("busy seen", rb_seen, 18'h1);
        chk("programs", dev.n_prog, 18'h1);
        op(3'h0, CMD_READ_SETUP, 13'h0000);
        op(3'h1, 8'h00, 13'h0003);
        op(3'h0, CMD_READ_START, 13'h0000);
        wait_rb();
        rd();
        chk("read byte 0", rd_got, 18'ha5);
        rd();
        chk("read byte 1", rd_got, 18'h3c);
        chk("column count", col_count, 18'h5);
    endtask : t_prog_read
    task automatic t_busy();
        op(3'h0, CMD_READ_SETUP, 13'h0000);
        op(3'h1, 8'h00, 13'h0003);
        op(3'h0, CMD_READ_START, 13'h0000);
        idle();
        op(3'h4, 8'h00, 13'h0000);
        chk("read while busy refused", refd, 18'h1);
        chk("busy blocks standby", dev.standby, 18'h0);
        op(3'h0, CMD_STATUS, 13'h0000);
        chk("status while busy taken", refd, 18'h0);
        wait_rb();
        chk("standby when ready", dev.standby, 18'h1);
        rd();
        chk("status byte", rd_got, 18'hc0);
        chk("fail flag clear", prog_fail, 18'h0);
        chk("strobes during busy", dev.n_viol, 18'h0);
    endtask : t_busy
    task automatic t_inhibit();
        clk_en = 1'b0;
        user_write_allow = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("guard pin frozen", wp_n, 18'h1);
        clk_en = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("guard pin low", wp_n, 18'h0);
        op(3'h0, CMD_DATA_LOAD, 13'h0000);
        op(3'h3, 8'h11, 13'h0000);
        chk("write data refused", refd, 18'h1);
        op(3'h1, 8'h00, PAGE_BYTES);
        chk("column past page refused", refd, 18'h1);
        op(3'h5, 8'h00, 13'h0000);
        chk("unknown kind refused", refd, 18'h1);
        op(3'h0, CMD_PROG, 13'h0000);
        op(3'h0, CMD_STATUS, 13'h0000);
        rd();
        chk("program inhibited", dev.n_prog, 18'h1);
        chk("status inhibited", rd_got, 18'h41);
        chk("fail flag set", prog_fail, 18'h1);
    endtask : t_inhibit
    initial
    begin
        repeat (8) @(posedge clk);
        chk("ce_n in reset", ce_n, 18'h1);
        chk("we_n in reset", we_n, 18'h1);
        chk("port released in reset", io_oe, 18'h0);
        #1;
        rstn = 1'b1;
        idle();
        chk("init select", power_on_init_select, 18'h1);
        cfg_psl = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("init select static", power_on_init_select, 18'h1);
        chk("guard pin high", wp_n, 18'h1);
        t_prog_read();
        t_busy();
        t_inhibit();
        end_of_test();
    end
endmodule : nand_bus_command_interface_tb_top
`default_nettype wire
